// ===== hw/nvc_pkg.sv
// Constants and types for the storage command and rail setting block
// Contract
// - The stored negative gate level sits in bits 5 to 0 of the last stored register, coded like the working one.
// - Any write to the commit command copies working registers 0x07-0x15 to stored registers 0x17-0x25 if idle, vprog_ok_pin high and under five commits done.
// - Any write to the reload command copies stored registers 0x17-0x25 back into working registers 0x07-0x15; writes while a copy runs are ignored.
// - A write to the restart command leaves latched fault mode, restarts operation and clears every fault;
//   it is ignored while a copy runs, and the latch stays set while fault_in_pin is high.
// - The positive analog rail level is a 6-bit value written into its setting register.
// - The negative analog rail uses the positive rail setting, with no setting of its own.
// - The positive gate level is taken from bits 5 to 0 of its setting register.
// - The negative gate level is taken from bits 5 to 0 of its setting register.
// - The switching rate is either 420 kHz or 2.1 MHz, picked by a configuration bit.
// - The data byte written to the commit or reload address is ignored; the write alone triggers.
// - A failed commit sets the storage write fault flag, which the host checks 20 ms later before retrying.
// - Storage accepts at most five successful commits over its life.
package nvc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_WORK_FIRST = 8'h07;
  localparam logic [7:0] ADDR_WORK_LAST  = 8'h15;
  localparam logic [7:0] ADDR_NV_FIRST   = 8'h17;
  localparam logic [7:0] ADDR_NV_LAST    = 8'h25;
  localparam logic [7:0] ADDR_FSW        = 8'h07;
  localparam logic [7:0] ADDR_AVDD       = 8'h13;
  localparam logic [7:0] ADDR_VGON       = 8'h14;
  localparam logic [7:0] ADDR_VGOFF      = 8'h15;
  localparam logic [7:0] ADDR_COMMIT     = 8'h78;
  localparam logic [7:0] ADDR_RELOAD     = 8'h79;
  localparam logic [7:0] ADDR_RESTART    = 8'h7A;
  localparam logic [7:0] ADDR_STATUS     = 8'h7B;
  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int         NV_WORDS      = 15;
  localparam int         IDX_W         = 4;
  localparam logic [3:0] IDX_LAST      = 4'hE;
  localparam logic [3:0] IDX_AVDD      = 4'hC;
  localparam logic [3:0] IDX_VGON      = 4'hD;
  localparam logic [3:0] IDX_VGOFF     = 4'hE;
  localparam logic [3:0] IDX_FSW       = 4'h0;
  localparam int         LEVEL_MSB     = 5;
  localparam int         PUMP_BIT      = 6;
  localparam int         FSW_BIT       = 7;
  localparam logic [7:0] WORK_RESET    = 8'h00;
  localparam logic [7:0] NV_BLANK      = 8'h00;
  localparam logic [7:0] CMD_READ_VAL  = 8'h00;
  localparam logic [2:0] BURN_LIMIT    = 3'h5;
  localparam int         ST_FAULT_BIT  = 0;
  localparam int         ST_LATCH_BIT  = 1;
  localparam int         ST_BUSY_BIT   = 2;
  localparam int         ST_COUNT_LSB  = 3;
  localparam int         ST_COUNT_MSB  = 5;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int         CLK_KHZ       = 20000;
  localparam int         FSW_LO_KHZ    = 420;
  localparam int         FSW_HI_KHZ    = 2100;
  localparam int         CHECK_WAIT_MS = 20;
  localparam logic [5:0] DIV_LO        = 6'(CLK_KHZ / FSW_LO_KHZ);
  localparam logic [5:0] DIV_HI        = 6'(CLK_KHZ / FSW_HI_KHZ);
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {NVC_DIR_COMMIT, NVC_DIR_RELOAD} nvc_dir_t;
  typedef enum {NVC_IDLE, NVC_RUN} nvc_seq_state_t;

  function automatic logic nvc_in_range(input logic [7:0] a, input logic [7:0] lo,
                                        input logic [7:0] hi);
    nvc_in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [3:0] nvc_index(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    nvc_index = d[3:0];
  endfunction
endpackage

// ===== hw/nvc_copy_if.sv
// Handshake between the command decoder and the copy sequencer
`timescale 1ns/10ps
interface nvc_copy_if;
  import nvc_pkg::*;
  logic       start;
  nvc_dir_t   dir;
  nvc_dir_t   dir_q;
  logic       busy;
  logic       step_valid;
  logic       done;
  logic [3:0] idx;
  modport seq  (input start, dir, output dir_q, busy, step_valid, done, idx);
  modport ctrl (output start, dir, input dir_q, busy, step_valid, done, idx);
endinterface

// ===== hw/nvc_copy_seq.sv
// Copy sequencer walking the fifteen setting registers one per cycle
`timescale 1ns/10ps
module nvc_copy_seq
  import nvc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Copy control
  nvc_copy_if.seq  cif
);
  nvc_seq_state_t state_reg;
  logic [3:0]     idx_reg;
  nvc_dir_t       dir_reg;
  logic           busy_reg;

  assign cif.busy       = busy_reg;
  assign cif.step_valid = busy_reg;
  assign cif.done       = busy_reg && (idx_reg == IDX_LAST);
  assign cif.idx        = idx_reg;
  assign cif.dir_q      = dir_reg;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= NVC_IDLE;
      idx_reg   <= 4'h0;
      dir_reg   <= NVC_DIR_COMMIT;
    end
    else
    begin
      case (state_reg)
        NVC_IDLE:
        begin
          if (cif.start)
          begin
            state_reg <= NVC_RUN;
            idx_reg   <= 4'h0;
            dir_reg   <= cif.dir;
          end
        end
        NVC_RUN:
        begin
          if (idx_reg == IDX_LAST)
            state_reg <= NVC_IDLE;
          else
            idx_reg <= idx_reg + 4'h1;
        end
        default: state_reg <= NVC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Busy flag, kept as a flop for the pin
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_reg <= 1'b0;
    else if ((state_reg == NVC_IDLE) && cif.start)
      busy_reg <= 1'b1;
    else if ((state_reg == NVC_RUN) && (idx_reg == IDX_LAST))
      busy_reg <= 1'b0;
  end
endmodule

// ===== hw/nvc_top.sv
// Storage commit, reload, restart and rail setting logic
`timescale 1ns/10ps
module nvc_top
  import nvc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Pins
  input  wire logic       vprog_ok_pin,
  input  wire logic       fault_in_pin,
  // Rail settings
  output logic      [5:0] avdd_level,
  output logic      [5:0] neg_analog_rail,
  output logic      [5:0] vgon_level,
  output logic            pump_stage_select,
  output logic      [5:0] vgoff_level,
  output logic      [5:0] stored_neg_gate_level,
  output logic            fsw_high,
  output logic            sw_tick,
  // Status
  output logic            nv_write_fault,
  output logic            fault_latched,
  output logic            restart_pulse,
  output logic            copy_busy
);
  logic [7:0] work_mem [NV_WORDS];
  logic [7:0] nv_mem   [NV_WORDS];
  logic [2:0] burn_count_reg;
  logic [2:0] sync_reg [2];
  logic [1:0] pin_reg;
  logic [5:0] div_reg;
  logic       sw_tick_reg;
  logic       fault_reg;
  logic       latch_reg;
  logic       restart_reg;
  logic [7:0] rdata_reg;
  logic       busy;
  logic       wr_commit;
  logic       wr_reload;
  logic       wr_restart;
  logic       commit_ok;
  logic       wr_work;
  logic [3:0] widx;
  logic [5:0] wlevel;
  logic       wpump;
  logic [5:0] div_end;
  logic [3:0] busy_len_reg;

  nvc_copy_if cif ();

  nvc_copy_seq u_seq (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cif     (cif.seq)
  );

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  assign busy       = cif.busy;
  assign wr_commit  = reg_wr_en && (reg_addr == ADDR_COMMIT) && !busy;
  assign wr_reload  = reg_wr_en && (reg_addr == ADDR_RELOAD) && !busy;
  assign wr_restart = reg_wr_en && (reg_addr == ADDR_RESTART) && !busy;
  assign commit_ok  = (burn_count_reg < BURN_LIMIT) && pin_reg[0];
  assign cif.start  = (wr_commit && commit_ok) || wr_reload;
  assign cif.dir    = wr_reload ? NVC_DIR_RELOAD : NVC_DIR_COMMIT;
  assign wr_work    = reg_wr_en && !busy && nvc_in_range(reg_addr, ADDR_WORK_FIRST,
                                                         ADDR_WORK_LAST);
  assign widx       = nvc_index(reg_addr, ADDR_WORK_FIRST);
  assign wlevel     = reg_wdata[LEVEL_MSB:0];
  assign wpump      = reg_wdata[PUMP_BIT];

  // ----------------------------------------
  // Rail outputs
  // ----------------------------------------
  assign avdd_level            = work_mem[IDX_AVDD][LEVEL_MSB:0];
  assign neg_analog_rail       = work_mem[IDX_AVDD][LEVEL_MSB:0];
  assign vgon_level            = work_mem[IDX_VGON][LEVEL_MSB:0];
  assign pump_stage_select     = work_mem[IDX_VGON][PUMP_BIT];
  assign vgoff_level           = work_mem[IDX_VGOFF][LEVEL_MSB:0];
  assign stored_neg_gate_level = nv_mem[IDX_VGOFF][LEVEL_MSB:0];
  assign fsw_high              = work_mem[IDX_FSW][FSW_BIT];
  assign sw_tick               = sw_tick_reg;
  assign nv_write_fault        = fault_reg;
  assign fault_latched         = latch_reg;
  assign restart_pulse         = restart_reg;
  assign copy_busy             = busy;
  assign reg_rdata             = rdata_reg;

  // ----------------------------------------
  // Working registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NV_WORDS; i++)
        work_mem[i] <= WORK_RESET;
    end
    else if (cif.step_valid && (cif.dir_q == NVC_DIR_RELOAD))
      work_mem[cif.idx] <= nv_mem[cif.idx];
    else if (wr_work)
      work_mem[widx] <= reg_wdata;
  end

  // ----------------------------------------
  // Stored registers and commit count
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NV_WORDS; i++)
        nv_mem[i] <= NV_BLANK;
    end
    else if (cif.step_valid && (cif.dir_q == NVC_DIR_COMMIT))
      nv_mem[cif.idx] <= work_mem[cif.idx];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      burn_count_reg <= 3'h0;
    else if (cif.done && (cif.dir_q == NVC_DIR_COMMIT))
      burn_count_reg <= burn_count_reg + 3'h1;
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_reg[0] <= 3'h0;
      sync_reg[1] <= 3'h0;
      pin_reg     <= 2'h0;
    end
    else
    begin
      sync_reg[0] <= {sync_reg[0][1:0], vprog_ok_pin};
      sync_reg[1] <= {sync_reg[1][1:0], fault_in_pin};
      for (int p = 0; p < 2; p++)
        if (sync_reg[p][1] == sync_reg[p][2])
          pin_reg[p] <= sync_reg[p][2];
    end
  end

  // ----------------------------------------
  // Fault flags
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_reg <= 1'b0;
    else if (wr_commit && !commit_ok)
      fault_reg <= 1'b1;
    else if (wr_restart || wr_commit)
      fault_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      latch_reg <= 1'b0;
    else if (pin_reg[1])
      latch_reg <= 1'b1;
    else if (wr_restart)
      latch_reg <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      restart_reg <= 1'b0;
    else
      restart_reg <= wr_restart;
  end

  // ----------------------------------------
  // Switching rate divider
  // ----------------------------------------
  assign div_end = (fsw_high ? DIV_HI : DIV_LO) - 6'h1;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_reg     <= 6'h0;
      sw_tick_reg <= 1'b0;
    end
    else if (div_reg >= div_end)
    begin
      div_reg     <= 6'h0;
      sw_tick_reg <= 1'b1;
    end
    else
    begin
      div_reg     <= div_reg + 6'h1;
      sw_tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_reg <= 8'h00;
    else if (reg_rd_en)
    begin
      if (nvc_in_range(reg_addr, ADDR_WORK_FIRST, ADDR_WORK_LAST))
        rdata_reg <= work_mem[nvc_index(reg_addr, ADDR_WORK_FIRST)];
      else if (nvc_in_range(reg_addr, ADDR_NV_FIRST, ADDR_NV_LAST))
        rdata_reg <= nv_mem[nvc_index(reg_addr, ADDR_NV_FIRST)];
      else if (reg_addr == ADDR_STATUS)
        rdata_reg <= {2'h0, burn_count_reg, busy, latch_reg, fault_reg};
      else
        rdata_reg <= CMD_READ_VAL;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Length of the current busy run
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_len_reg <= 4'h0;
    else if (copy_busy)
      busy_len_reg <= busy_len_reg + 4'h1;
    else
      busy_len_reg <= 4'h0;
  end

  AST_COMMIT_COPY:
    assert property (cif.done && cif.dir_q == NVC_DIR_COMMIT |=>
                     stored_neg_gate_level == vgoff_level)
    else $error("commit did not copy settings");
  AST_RELOAD_COPY:
    assert property (cif.done && cif.dir_q == NVC_DIR_RELOAD |=>
                     vgoff_level == stored_neg_gate_level)
    else $error("reload did not copy settings");
  AST_RESTART_CLEARS:
    assert property (wr_restart |=> !nv_write_fault && restart_pulse)
    else $error("restart did not clear faults");
  AST_AVDD_WRITE:
    assert property (wr_work && reg_addr == ADDR_AVDD |=> avdd_level == $past(wlevel))
    else $error("positive rail setting not taken");
  AST_NEG_RAIL:
    assert property (wr_work && reg_addr == ADDR_AVDD |=> neg_analog_rail == $past(wlevel))
    else $error("negative rail does not follow positive");
  AST_VGON_WRITE:
    assert property (wr_work && reg_addr == ADDR_VGON |=>
                     vgon_level == $past(wlevel) && pump_stage_select == $past(wpump))
    else $error("positive gate setting not taken");
  AST_VGOFF_WRITE:
    assert property (wr_work && reg_addr == ADDR_VGOFF |=> vgoff_level == $past(wlevel))
    else $error("negative gate setting not taken");
  AST_TICK_SPACING:
    assert property (sw_tick |=> !sw_tick [*8])
    else $error("switching ticks too close");
  AST_RELOAD_ANY_DATA:
    assert property (wr_reload |=> ##14 (copy_busy && busy_len_reg == IDX_LAST)
                     ##1 !copy_busy)
    else $error("reload copy length wrong");
  AST_FAIL_FLAG:
    assert property (wr_commit && !commit_ok |=> nv_write_fault && !copy_busy)
    else $error("failed commit not flagged");
  AST_BURN_LIMIT:
    assert property (burn_count_reg <= BURN_LIMIT)
    else $error("commit count over limit");
  AST_CMD_READ_ZERO:
    assert property (reg_rd_en && reg_addr == ADDR_COMMIT |=> reg_rdata == CMD_READ_VAL)
    else $error("command register read not zero");

  COV_COMMIT: cover property (wr_commit && commit_ok ##16 !copy_busy);
  COV_RELOAD: cover property (wr_reload ##16 !copy_busy);
  COV_FAIL:   cover property (wr_commit && !commit_ok ##1 nv_write_fault);
  COV_RESTART: cover property (fault_latched ##1 wr_restart);
endmodule

// ===== sim/nvc_host_model.sv
// Host model driving the register port of the storage command block
`timescale 1ns/10ps
module nvc_host_model
  import nvc_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // Register port
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // ----------------------------------------
  // Register cycles
  // ----------------------------------------
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    reg_wr_en = 1'b1;
    reg_addr  = addr;
    reg_wdata = data;
    @(posedge sys_clk);
    #1;
    reg_wr_en = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    #1;
    reg_rd_en = 1'b1;
    reg_addr  = addr;
    @(posedge sys_clk);
    #1;
    reg_rd_en = 1'b0;
    reg_addr  = ~addr;
    data      = reg_rdata;
  endtask

  // ----------------------------------------
  // Host procedures
  // ----------------------------------------
  // Gate level with doubler choice when twice the supply suffices
  task automatic set_gate(input logic [5:0] level, input logic doubled);
    wr(ADDR_VGON, {1'b0, doubled, level});
  endtask

  // Commit, wait a shortened check time, then fetch status
  task automatic commit_check(input int wait_cyc, output logic [7:0] status);
    wr(ADDR_COMMIT, 8'hC3);
    repeat (wait_cyc) @(posedge sys_clk);
    rd(ADDR_STATUS, status);
  endtask
endmodule

// ===== sim/nvc_tb_top.sv
// Self-checking testbench for the storage command block
`timescale 1ns/10ps
module nvc_tb_top
  import nvc_pkg::*;
;
  logic       sys_clk;
  logic       rst_n;
  logic       reg_wr_en;
  logic       reg_rd_en;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       vprog_ok_pin;
  logic       fault_in_pin;
  logic [5:0] avdd_level;
  logic [5:0] neg_analog_rail;
  logic [5:0] vgon_level;
  logic       pump_stage_select;
  logic [5:0] vgoff_level;
  logic [5:0] stored_neg_gate_level;
  logic       fsw_high;
  logic       sw_tick;
  logic       nv_write_fault;
  logic       fault_latched;
  logic       restart_pulse;
  logic       copy_busy;
  int         errors;
  int         n_checks;
  int         cycles;
  logic [7:0] rv;

  nvc_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .vprog_ok_pin(vprog_ok_pin), .fault_in_pin(fault_in_pin),
    .avdd_level(avdd_level), .neg_analog_rail(neg_analog_rail), .vgon_level(vgon_level),
    .pump_stage_select(pump_stage_select), .vgoff_level(vgoff_level),
    .stored_neg_gate_level(stored_neg_gate_level), .fsw_high(fsw_high),
    .sw_tick(sw_tick), .nv_write_fault(nv_write_fault), .fault_latched(fault_latched),
    .restart_pulse(restart_pulse), .copy_busy(copy_busy));

  nvc_host_model i_host (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      errors++;
      conclude();
    end
  end

  task automatic conclude;
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (copy_busy !== 1'b0 && k < 40)
    begin
      step(1);
      k++;
    end
    check(16'(copy_busy), 16'h0);
  endtask

  task automatic tick_gap(output int n);
    int k;
    k = 0;
    while (sw_tick !== 1'b1 && k < 100)
    begin
      step(1);
      k++;
    end
    step(1);
    n = 1;
    while (sw_tick !== 1'b1 && n < 100)
    begin
      step(1);
      n++;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [7:0] addrs [5];
    addrs = '{ADDR_COMMIT, ADDR_RELOAD, ADDR_RESTART, 8'h60, ADDR_STATUS};
    check(16'({vgoff_level, stored_neg_gate_level}), 16'h0);
    check(16'(avdd_level), 16'h0);
    foreach (addrs[i])
    begin
      i_host.rd(addrs[i], rv);
      check(16'(rv), 16'h0);
    end
  endtask

  task automatic t_rails;
    int g;
    i_host.wr(ADDR_AVDD, 8'hEA);
    i_host.set_gate(6'h15, 1'b1);
    i_host.wr(ADDR_VGOFF, 8'h3F);
    step(1);
    check(16'(avdd_level), 16'h2A);
    check(16'(neg_analog_rail), 16'h2A);
    check(16'(vgon_level), 16'h15);
    check(16'(pump_stage_select), 16'h1);
    check(16'(vgoff_level), 16'h3F);
    i_host.wr(ADDR_FSW, 8'h80);
    tick_gap(g);
    tick_gap(g);
    check(16'(fsw_high), 16'h1);
    check(16'(g), 16'(CLK_KHZ / FSW_HI_KHZ));
    i_host.wr(ADDR_FSW, 8'h00);
    tick_gap(g);
    tick_gap(g);
    check(16'(fsw_high), 16'h0);
    check(16'(g), 16'(CLK_KHZ / FSW_LO_KHZ));
  endtask

  task automatic t_commit;
    vprog_ok_pin = 1'b1;
    step(6);
    i_host.wr(ADDR_COMMIT, 8'hA5);
    step(2);
    check(16'(copy_busy), 16'h1);
    i_host.wr(ADDR_VGOFF, 8'h01);
    wait_idle();
    check(16'(vgoff_level), 16'h3F);
    check(16'(stored_neg_gate_level), 16'h3F);
    i_host.rd(8'h25, rv);
    check(16'(rv), 16'h3F);
    i_host.rd(ADDR_STATUS, rv);
    check(16'(rv), 16'h08);
  endtask

  task automatic t_reload;
    i_host.wr(ADDR_VGOFF, 8'h0C);
    i_host.wr(ADDR_AVDD, 8'h01);
    i_host.set_gate(6'h02, 1'b0);
    step(1);
    check(16'(vgoff_level), 16'h0C);
    i_host.wr(ADDR_RELOAD, 8'h5A);
    step(2);
    check(16'(copy_busy), 16'h1);
    wait_idle();
    check(16'({avdd_level, neg_analog_rail}), 16'hAAA);
    check(16'({pump_stage_select, vgon_level, vgoff_level}), 16'h157F);
  endtask

  task automatic t_fail_restart;
    int p;
    vprog_ok_pin = 1'b0;
    step(6);
    i_host.wr(ADDR_COMMIT, 8'h00);
    step(2);
    check(16'({nv_write_fault, copy_busy}), 16'h2);
    fault_in_pin = 1'b1;
    step(6);
    fault_in_pin = 1'b0;
    step(6);
    i_host.rd(ADDR_STATUS, rv);
    check(16'(rv), 16'h0B);
    p = 0;
    fork
      i_host.wr(ADDR_RESTART, 8'h00);
      repeat (4)
      begin
        step(1);
        if (restart_pulse === 1'b1)
          p++;
      end
    join
    check(16'(p), 16'h1);
    check(16'({nv_write_fault, fault_latched}), 16'h0);
  endtask

  task automatic t_limit;
    vprog_ok_pin = 1'b1;
    step(6);
    for (int i = 0; i < 4; i++)
    begin
      i_host.commit_check(20, rv);
      check(16'(rv), 16'((i + 2) << 3));
    end
    i_host.commit_check(20, rv);
    check(16'(rv), 16'h29);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    errors       = 0;
    n_checks     = 0;
    cycles       = 0;
    rst_n        = 1'b0;
    vprog_ok_pin = 1'b0;
    fault_in_pin = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_rails();
    t_commit();
    t_reload();
    t_fail_restart();
    t_limit();
    conclude();
  end
endmodule
